/* rtl/ctpc_map.svh */
// Register offsets, field positions and constants of the transfer checker
`ifndef CTPC_MAP_SVH
`define CTPC_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CTPC_OFF_CTRL   8'h00
`define CTPC_OFF_SEL    8'h04
`define CTPC_OFF_DESC   8'h08
`define CTPC_OFF_GATE   8'h0C
`define CTPC_OFF_TSS0   8'h10
`define CTPC_OFF_OUTER  8'h1C
`define CTPC_OFF_ADJ    8'h20
`define CTPC_OFF_CS     8'h24
`define CTPC_OFF_STK    8'h28
`define CTPC_OFF_STATUS 8'h2C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTPC_CTRL_OP    2:0
`define CTPC_CTRL_GO    8
`define CTPC_SEL_RPL    1:0
`define CTPC_SEL_TI     2
`define CTPC_SEL_IDX    15:2
`define CTPC_DESC_TYPE  2:0
`define CTPC_DESC_DPL   4:3
`define CTPC_DESC_CONF  5
`define CTPC_GATE_CNT   12:8
`define CTPC_GATE_SEL   31:16
`define CTPC_SEG_HI     31:16
`define CTPC_SEG_LO     15:0
`define CTPC_ST_BUSY    0
`define CTPC_ST_FAULT   1
`define CTPC_ST_TS      2
`define CTPC_ST_SWAP    3
`define CTPC_ST_COPIED  12:8
`define CTPC_ST_CPL     17:16
`define CTPC_ST_VEC     31:24

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define CTPC_RST_CS     16'h0000
`define CTPC_RST_STK    32'h0000_0000
`define CTPC_FAULT_VEC  8'h0D
`define CTPC_PUSH_BYTES 16'h0004

`endif

/* rtl/ctpc_pkg.sv */
// Types shared by the control transfer privilege checker
package ctpc_pkg;

   // Operation that loads the code segment register
   typedef enum logic [2:0] {
      CT_JMP  = 3'h0,
      CT_CALL = 3'h1,
      CT_RET  = 3'h2,
      CT_INTR_EXIT_INSTR = 3'h3,
      CT_INTR = 3'h4
   } ctpc_op_e;

   // Descriptor type referenced by the selector
   typedef enum logic [2:0] {
      DT_CODE      = 3'h0,
      DT_CALL_GATE = 3'h1,
      DT_INTR_GATE = 3'h2,
      DT_TASK_GATE = 3'h3,
      DT_TSS       = 3'h4,
      DT_DATA      = 3'h5
   } ctpc_dtype_e;

   // Gray codes along idle, check, commit
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_CHECK  = 2'b01,
      ST_COMMIT = 2'b11,
      ST_FAULT  = 2'b10
   } ctpc_state_e;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } ctpc_wb_req_s;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } ctpc_wb_rsp_s;

   typedef struct packed {
      logic ok;
      logic ts;
      logic swap;
      logic [1:0] current_priv_level;
      logic [15:0] cs;
      logic [15:0] ss;
      logic [15:0] sp;
      logic [4:0] copy;
   } ctpc_chk_s;

   typedef struct packed {
      ctpc_state_e st;
      ctpc_op_e op;
      logic [15:0] sel;
      logic [31:0] desc;
      logic [31:0] gate;
      logic [2:0][31:0] task_state_segment;
      logic [31:0] outer;
      logic [15:0] adj;
      logic [15:0] cs;
      logic [31:0] stk;
      ctpc_chk_s pend;
      logic [4:0] copy_left;
      logic [4:0] copied;
      logic fault_st;
      logic ts_st;
      logic swap_st;
      logic fault_p;
      logic ts_p;
      logic ack;
      logic [31:0] rdat;
   } ctpc_state_s;

endpackage

/* rtl/ctpc_top.sv */
// Control transfer privilege checker with a classic Wishbone slave
`timescale 1ns/1ps
`include "ctpc_map.svh"

module ctpc_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire ctpc_pkg::ctpc_wb_req_s wb_req_i,
   output ctpc_pkg::ctpc_wb_rsp_s wb_rsp_o,
   // Transfer events and level
   output logic fault_o,
   output logic task_switch_o,
   output logic [1:0] cpl_o
);
   import ctpc_pkg::*;

   ctpc_state_s q;
   ctpc_state_s next_q;

   // ------------------------------------------------------------------
   // Byte lane merge for partial writes
   // ------------------------------------------------------------------
   function automatic logic [31:0] bmerge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------------
   // Privilege judgement of one pending transfer
   // ------------------------------------------------------------------
   function automatic ctpc_chk_s judge(input ctpc_state_s s);
      ctpc_chk_s c;
      logic [1:0] current_priv_level;
      logic [1:0] requested_priv_level;
      logic [1:0] descriptor_priv_level;
      logic [1:0] gdpl;
      logic conf;
      logic ti;
      logic xfer;
      logic [15:0] pcnt;
      logic [31:0] nstk;
      ctpc_dtype_e dt;
      ctpc_dtype_e global_descriptor_table;
      current_priv_level = s.cs[`CTPC_SEL_RPL];
      requested_priv_level = s.sel[`CTPC_SEL_RPL];
      ti = s.sel[`CTPC_SEL_TI];
      descriptor_priv_level = s.desc[`CTPC_DESC_DPL];
      conf = s.desc[`CTPC_DESC_CONF];
      gdpl = s.gate[`CTPC_DESC_DPL];
      dt = ctpc_dtype_e'(s.desc[`CTPC_DESC_TYPE]);
      global_descriptor_table = ctpc_dtype_e'(s.gate[`CTPC_DESC_TYPE]);
      xfer = (s.op == CT_JMP) || (s.op == CT_CALL);
      pcnt = 16'h0000;
      nstk = 32'h0000_0000;
      c = '0;
      c.current_priv_level = current_priv_level;
      c.cs = s.cs;
      c.ss = s.stk[`CTPC_SEG_HI];
      c.sp = s.stk[`CTPC_SEG_LO];
      // Numerically lower level is the more privileged one
      case (dt)
         DT_CODE: begin
            if (xfer) begin
               c.ok = (conf ? descriptor_priv_level <= current_priv_level : descriptor_priv_level == current_priv_level)
                      && (requested_priv_level <= current_priv_level);
               c.cs = {s.sel[`CTPC_SEL_IDX], current_priv_level};
            end else if (s.op == CT_RET || s.op == CT_INTR_EXIT_INSTR) begin
               // Never return inward to a more privileged level
               c.ok = (descriptor_priv_level >= current_priv_level) && (requested_priv_level >= current_priv_level);
               c.current_priv_level = requested_priv_level;
               c.cs = s.sel;
               if (requested_priv_level != current_priv_level) begin
                  c.swap = 1'b1;
                  c.ss = s.outer[`CTPC_SEG_HI];
                  c.sp = s.outer[`CTPC_SEG_LO] + s.adj;
               end else begin
                  c.sp = c.sp + s.adj;
               end
            end
         end
         DT_CALL_GATE, DT_INTR_GATE: begin
            c.ok = ((dt == DT_CALL_GATE) ? s.op == CT_CALL
                                         : s.op == CT_INTR)
                   && (descriptor_priv_level >= current_priv_level);
            if (global_descriptor_table == DT_TSS) begin
               c.ts = 1'b1;
            end else if (global_descriptor_table == DT_CODE && gdpl <= current_priv_level) begin
               c.current_priv_level = gdpl;
               c.cs = {s.gate[31:18], gdpl};
               if (gdpl != current_priv_level) begin
                  nstk = s.task_state_segment[gdpl];
                  if (dt == DT_CALL_GATE) begin
                     pcnt = {11'h000, s.gate[`CTPC_GATE_CNT]};
                     c.copy = s.gate[`CTPC_GATE_CNT];
                  end
                  c.swap = 1'b1;
                  c.ss = nstk[`CTPC_SEG_HI];
                  c.sp = nstk[`CTPC_SEG_LO] - `CTPC_PUSH_BYTES
                         - (pcnt << 1);
               end
            end else begin
               c.ok = 1'b0;
            end
         end
         DT_TASK_GATE: begin
            c.ok = (xfer || s.op == CT_INTR) && (descriptor_priv_level >= current_priv_level);
            c.ts = 1'b1;
         end
         DT_TSS: begin
            c.ok = xfer && !ti && (descriptor_priv_level >= current_priv_level);
            c.ts = 1'b1;
         end
         default: begin
            c.ok = 1'b0;
         end
      endcase
      return c;
   endfunction

   // ------------------------------------------------------------------
   // Read data mux
   // ------------------------------------------------------------------
   function automatic logic [31:0] rd(input ctpc_state_s s,
                                      input logic [7:0] adr);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (adr)
         `CTPC_OFF_CTRL: r = {29'h0, s.op};
         `CTPC_OFF_SEL: r = {16'h0000, s.sel};
         `CTPC_OFF_DESC: r = s.desc;
         `CTPC_OFF_GATE: r = s.gate;
         `CTPC_OFF_TSS0: r = s.task_state_segment[0];
         `CTPC_OFF_TSS0 + 8'h04: r = s.task_state_segment[1];
         `CTPC_OFF_TSS0 + 8'h08: r = s.task_state_segment[2];
         `CTPC_OFF_OUTER: r = s.outer;
         `CTPC_OFF_ADJ: r = {16'h0000, s.adj};
         `CTPC_OFF_CS: r = {16'h0000, s.cs};
         `CTPC_OFF_STK: r = s.stk;
         `CTPC_OFF_STATUS: begin
            r[`CTPC_ST_BUSY] = (s.st != ST_IDLE);
            r[`CTPC_ST_FAULT] = s.fault_st;
            r[`CTPC_ST_TS] = s.ts_st;
            r[`CTPC_ST_SWAP] = s.swap_st;
            r[`CTPC_ST_COPIED] = s.copied;
            r[`CTPC_ST_CPL] = s.cs[`CTPC_SEL_RPL];
            r[`CTPC_ST_VEC] = s.fault_st ? `CTPC_FAULT_VEC : 8'h00;
         end
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [31:0] w;
      logic hit;
      ctpc_chk_s c;
      w = 32'h0000_0000;
      c = '0;
      hit = wb_req_i.cyc && wb_req_i.stb && !q.ack;
      next_q = q;
      next_q.fault_p = 1'b0;
      next_q.ts_p = 1'b0;
      next_q.ack = hit;
      if (hit) begin
         next_q.rdat = rd(q, wb_req_i.adr);
      end
      if (hit && wb_req_i.we) begin
         w = bmerge(rd(q, wb_req_i.adr), wb_req_i.dat, wb_req_i.sel);
         case (wb_req_i.adr)
            `CTPC_OFF_CTRL: begin
               // Start is ignored while a transfer is in flight
               if (q.st == ST_IDLE && w[`CTPC_CTRL_GO]) begin
                  next_q.op = ctpc_op_e'(w[`CTPC_CTRL_OP]);
                  next_q.st = ST_CHECK;
               end
            end
            `CTPC_OFF_SEL: next_q.sel = w[15:0];
            `CTPC_OFF_DESC: next_q.desc = w;
            `CTPC_OFF_GATE: next_q.gate = w;
            `CTPC_OFF_TSS0: next_q.task_state_segment[0] = w;
            `CTPC_OFF_TSS0 + 8'h04: next_q.task_state_segment[1] = w;
            `CTPC_OFF_TSS0 + 8'h08: next_q.task_state_segment[2] = w;
            `CTPC_OFF_OUTER: next_q.outer = w;
            `CTPC_OFF_ADJ: next_q.adj = w[15:0];
            `CTPC_OFF_CS: next_q.cs = w[15:0];
            `CTPC_OFF_STK: next_q.stk = w;
            `CTPC_OFF_STATUS: begin
               // Write one to clear; events below win the same cycle
               next_q.fault_st = q.fault_st & ~w[`CTPC_ST_FAULT];
               next_q.ts_st = q.ts_st & ~w[`CTPC_ST_TS];
               next_q.swap_st = q.swap_st & ~w[`CTPC_ST_SWAP];
            end
            default: begin
            end
         endcase
      end
      case (q.st)
         ST_IDLE: begin
         end
         ST_CHECK: begin
            c = judge(q);
            next_q.pend = c;
            next_q.copy_left = c.copy;
            next_q.copied = 5'h00;
            next_q.st = c.ok ? ST_COMMIT : ST_FAULT;
         end
         ST_COMMIT: begin
            if (q.copy_left != 5'h00) begin
               // One parameter word moved per cycle
               next_q.copy_left = q.copy_left - 5'h01;
               next_q.copied = q.copied + 5'h01;
            end else begin
               if (q.pend.ts) begin
                  next_q.ts_p = 1'b1;
                  next_q.ts_st = 1'b1;
               end else begin
                  next_q.cs = q.pend.cs;
                  next_q.stk = {q.pend.ss, q.pend.sp};
                  // Set wins over a clear landing in the same cycle
                  next_q.swap_st = next_q.swap_st | q.pend.swap;
               end
               next_q.st = ST_IDLE;
            end
         end
         ST_FAULT: begin
            // Nothing architectural is touched on a failed check
            next_q.fault_p = 1'b1;
            next_q.fault_st = 1'b1;
            next_q.st = ST_IDLE;
         end
         default: begin
            next_q.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.cs <= `CTPC_RST_CS;
         q.stk <= `CTPC_RST_STK;
      end else begin
         q <= next_q;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign wb_rsp_o.ack = q.ack;
   assign wb_rsp_o.dat = q.rdat;
   assign fault_o = q.fault_p;
   assign task_switch_o = q.ts_p;
   assign cpl_o = q.cs[`CTPC_SEL_RPL];

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_ret_type;
      @(posedge clk_i) disable iff (rst_i)
      (q.st == ST_CHECK && q.op == CT_RET && q.desc[2:0] == DT_TSS)
      |=> (q.st == ST_FAULT) ##1 fault_o;
   endproperty
   a_ret_type: assert property (p_ret_type)
      else $error("return to task segment did not fault");

   property p_direct_level;
      @(posedge clk_i) disable iff (rst_i)
      (q.st == ST_CHECK && q.op == CT_JMP && q.desc[2:0] == DT_CODE
       && !q.desc[`CTPC_DESC_CONF] && q.desc[4:3] != q.cs[1:0])
      |=> q.st == ST_FAULT;
   endproperty
   a_direct_level: assert property (p_direct_level)
      else $error("non-conforming jump at other level accepted");

   property p_rpl;
      @(posedge clk_i) disable iff (rst_i)
      (q.st == ST_CHECK && q.op == CT_CALL && q.desc[2:0] == DT_CODE
       && q.sel[1:0] > q.cs[1:0])
      |=> q.st == ST_FAULT;
   endproperty
   a_rpl: assert property (p_rpl)
      else $error("call with weak requested level accepted");

   property p_ret_dpl;
      @(posedge clk_i) disable iff (rst_i)
      (q.st == ST_CHECK && q.op == CT_INTR_EXIT_INSTR && q.desc[2:0] == DT_CODE
       && q.desc[4:3] < q.cs[1:0])
      |=> q.st == ST_FAULT;
   endproperty
   a_ret_dpl: assert property (p_ret_dpl)
      else $error("inward return accepted");

   property p_ret_cpl;
      @(posedge clk_i) disable iff (rst_i)
      (q.st == ST_CHECK && q.op == CT_RET && q.desc[2:0] == DT_CODE
       && q.desc[4:3] >= q.cs[1:0] && q.sel[1:0] >= q.cs[1:0])
      |-> ##2 (cpl_o == $past(q.sel[1:0], 2));
   endproperty
   a_ret_cpl: assert property (p_ret_cpl)
      else $error("level after return differs from selector");

   property p_tss;
      @(posedge clk_i) disable iff (rst_i)
      (q.st == ST_CHECK && q.op == CT_JMP && q.desc[2:0] == DT_TSS
       && !q.sel[2] && q.desc[4:3] >= q.cs[1:0])
      |-> ##2 (task_switch_o && $stable(q.cs));
   endproperty
   a_tss: assert property (p_tss)
      else $error("task segment jump did not switch task");

   property p_gate_dpl;
      @(posedge clk_i) disable iff (rst_i)
      (q.st == ST_CHECK && q.desc[2:0] == DT_CALL_GATE
       && q.desc[4:3] < q.cs[1:0])
      |=> q.st == ST_FAULT;
   endproperty
   a_gate_dpl: assert property (p_gate_dpl)
      else $error("privileged gate accepted");

   property p_copy;
      @(posedge clk_i) disable iff (rst_i)
      (q.st == ST_COMMIT && q.copy_left != 5'h00)
      |=> (q.st == ST_COMMIT && q.copied == $past(q.copied) + 5'h01);
   endproperty
   a_copy: assert property (p_copy)
      else $error("parameter copy stalled");

   property p_fault_hold;
      @(posedge clk_i) disable iff (rst_i)
      (q.st == ST_FAULT)
      |=> (fault_o && $stable(q.cs) && $stable(q.stk)
           && q.st == ST_IDLE);
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("state changed on failed check");

endmodule

/* bench/ctpc_tb_top.sv */
// Self-checking bench for the control transfer privilege checker
`timescale 1ns/1ps
`include "ctpc_map.svh"

module tb_top;
   import ctpc_pkg::*;

   // ----------------------------------------------------------------
   // Types, signals and counters
   // ----------------------------------------------------------------
   typedef struct packed {
      ctpc_op_e op;
      logic [1:0] cpl0;
      logic [15:0] sel;
      logic [31:0] desc;
      logic [31:0] gate;
      logic f;
      logic ts;
      logic [1:0] current_priv_level;
      logic [31:0] stk;
   } ctpc_tb_row_s;

   logic clk_i;
   logic rst_i;
   ctpc_wb_req_s wb_req_i;
   ctpc_wb_rsp_s wb_rsp_o;
   logic fault_o;
   logic task_switch_o;
   logic [1:0] cpl_o;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int n_fault = 0;
   int n_ts = 0;
   ctpc_tb_row_s rows[$];
   ctpc_tb_row_s r;
   logic [31:0] q;
   logic [31:0] exp_stk;
   logic [1:0] ecpl;
   int nf;
   int nt;

   ctpc_top i_ctpc_top (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_req_i(wb_req_i),
      .wb_rsp_o(wb_rsp_o),
      .fault_o(fault_o),
      .task_switch_o(task_switch_o),
      .cpl_o(cpl_o)
   );

   always #12.5 clk_i = ~clk_i;

   // Pulses stand one cycle, so they are counted at every edge
   always @(posedge clk_i) begin
      cycles++;
      if (fault_o === 1'b1) n_fault++;
      if (task_switch_o === 1'b1) n_ts++;
      if (cycles == 30000) begin
         errors++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_rsp_o.ack !== 1'b1 && n < 50);
      rq = wb_rsp_o.dat;
      wb_req_i <= '0;
      if (n >= 50) begin
         errors++;
         summarize();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      wb(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] rq);
      wb(1'b0, a, 32'h0000_0000, rq);
   endtask

   task automatic go(input ctpc_op_e op);
      wr(`CTPC_OFF_CTRL, {23'h0, 1'b1, 5'h0, op});
   endtask

   task automatic wait_idle();
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         rd(`CTPC_OFF_STATUS, s);
         n++;
      end while (s[0] !== 1'b0 && n < 100);
      if (n >= 100) errors++;
   endtask

   function automatic logic [31:0] d(ctpc_dtype_e t, logic [1:0] p,
                                     logic c);
      return {26'h0, c, p, t};
   endfunction

   function automatic logic [31:0] g(ctpc_dtype_e t, logic [1:0] p,
                                     logic [4:0] n);
      return {16'h0010, 3'h0, n, 3'h0, p, t};
   endfunction

   // Stack field: 0 unchanged, 1 same-level pop by the adjustment
   function automatic ctpc_tb_row_s mk(ctpc_op_e op, logic [1:0] c0,
      logic [15:0] s, logic [31:0] de, logic [31:0] ga, logic f,
      logic ts, logic [1:0] c, logic [31:0] st);
      return '{op, c0, s, de, ga, f, ts, c, st};
   endfunction

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      wb_req_i = '0;
      exp_stk = `CTPC_RST_STK;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(cpl_o, 2'h0);
      rd(`CTPC_OFF_CS, q);
      chk(q, {16'h0, `CTPC_RST_CS});
      rd(`CTPC_OFF_STK, q);
      chk(q, `CTPC_RST_STK);
      wr(`CTPC_OFF_TSS0, 32'h1000_0100);
      wr(`CTPC_OFF_TSS0 + 8'h04, 32'h1100_0200);
      wr(`CTPC_OFF_TSS0 + 8'h08, 32'h1200_0300);
      wr(`CTPC_OFF_OUTER, 32'h3300_0400);
      wr(`CTPC_OFF_ADJ, 32'h0000_0008);
      rows.push_back(mk(CT_JMP, 2, 16'h000A, d(DT_CODE, 2, 0), 0, 0, 0, 2, 0));
      rows.push_back(mk(CT_JMP, 2, 16'h000A, d(DT_CODE, 1, 0), 0, 1, 0, 0, 0));
      rows.push_back(mk(CT_CALL, 2, 16'h000A, d(DT_CODE, 1, 1), 0, 0, 0, 2, 0));
      rows.push_back(mk(CT_CALL, 2, 16'h000A, d(DT_CODE, 3, 1), 0, 1, 0, 0, 0));
      rows.push_back(mk(CT_JMP, 2, 16'h000B, d(DT_CODE, 2, 0), 0, 1, 0, 0, 0));
      rows.push_back(mk(CT_JMP, 3, 16'h000B, d(DT_CALL_GATE, 3, 0),
                        g(DT_CODE, 3, 0), 1, 0, 0, 0));
      rows.push_back(mk(CT_RET, 2, 16'h000A, d(DT_TSS, 2, 0), 0, 1, 0, 0, 0));
      rows.push_back(mk(CT_JMP, 2, 16'h000A, d(DT_DATA, 2, 0), 0, 1, 0, 0, 0));
      rows.push_back(mk(CT_INTR, 3, 16'h000B, d(DT_CODE, 3, 0), 0, 1, 0, 0, 0));
      rows.push_back(mk(CT_JMP, 2, 16'h000A, d(DT_TSS, 3, 0), 0, 0, 1, 0, 0));
      rows.push_back(mk(CT_JMP, 2, 16'h000A, d(DT_TSS, 1, 0), 0, 1, 0, 0, 0));
      rows.push_back(mk(CT_CALL, 2, 16'h000E, d(DT_TSS, 3, 0), 0, 1, 0, 0, 0));
      rows.push_back(mk(CT_JMP, 2, 16'h000E, d(DT_TASK_GATE, 3, 0),
                        g(DT_TSS, 3, 0), 0, 1, 0, 0));
      rows.push_back(mk(CT_CALL, 3, 16'h000B, d(DT_CALL_GATE, 3, 0),
                        g(DT_CODE, 0, 3), 0, 0, 0, 32'h1000_00F6));
      rows.push_back(mk(CT_CALL, 2, 16'h000A, d(DT_CALL_GATE, 1, 0),
                        g(DT_CODE, 0, 0), 1, 0, 0, 0));
      rows.push_back(mk(CT_CALL, 2, 16'h000A, d(DT_CALL_GATE, 3, 0),
                        g(DT_CODE, 3, 0), 1, 0, 0, 0));
      rows.push_back(mk(CT_CALL, 2, 16'h000A, d(DT_CALL_GATE, 3, 0),
                        g(DT_TSS, 3, 0), 0, 1, 0, 0));
      rows.push_back(mk(CT_INTR, 3, 16'h000B, d(DT_INTR_GATE, 3, 0),
                        g(DT_CODE, 1, 0), 0, 0, 1, 32'h1100_01FC));
      rows.push_back(mk(CT_INTR, 3, 16'h000B, d(DT_INTR_GATE, 0, 0),
                        g(DT_CODE, 0, 0), 1, 0, 0, 0));
      rows.push_back(mk(CT_INTR, 3, 16'h000B, d(DT_TASK_GATE, 3, 0),
                        g(DT_TSS, 3, 0), 0, 1, 0, 0));
      rows.push_back(mk(CT_RET, 2, 16'h000A, d(DT_CODE, 2, 0), 0, 0, 0, 2, 1));
      rows.push_back(mk(CT_RET, 1, 16'h000B, d(DT_CODE, 3, 0), 0, 0, 0, 3,
                        32'h3300_0408));
      rows.push_back(mk(CT_INTR_EXIT_INSTR, 1, 16'h0009, d(DT_CODE, 0, 0), 0, 1, 0, 0, 0));
      rows.push_back(mk(CT_INTR_EXIT_INSTR, 3, 16'h000B, d(DT_CODE, 3, 0), 0, 0, 0, 3, 1));
      foreach (rows[i]) begin
         r = rows[i];
         wr(`CTPC_OFF_CS, {16'h0, 16'h0020 | r.cpl0});
         wr(`CTPC_OFF_SEL, {16'h0, r.sel});
         wr(`CTPC_OFF_DESC, r.desc);
         wr(`CTPC_OFF_GATE, r.gate);
         wr(`CTPC_OFF_STATUS, 32'h0000_000E);
         nf = n_fault;
         nt = n_ts;
         go(r.op);
         wait_idle();
         ecpl = r.cpl0;
         if (!(r.f | r.ts)) begin
            ecpl = r.current_priv_level;
            if (r.stk == 32'h1) exp_stk[15:0] = exp_stk[15:0] + 16'h0008;
            else if (r.stk != 32'h0) exp_stk = r.stk;
         end
         chk(n_fault - nf, r.f);
         chk(n_ts - nt, r.ts);
         chk(cpl_o, ecpl);
         rd(`CTPC_OFF_STK, q);
         chk(q, exp_stk);
         rd(`CTPC_OFF_CS, q);
         if (r.f | r.ts) chk(q, {16'h0, 16'h0020 | r.cpl0});
         else if (r.op == CT_RET || r.op == CT_INTR_EXIT_INSTR) chk(q, {16'h0, r.sel});
         rd(`CTPC_OFF_STATUS, q);
         chk(q & 32'hFF00_000E, {r.f ? `CTPC_FAULT_VEC : 8'h00, 20'h0,
             r.stk > 32'h1 && !(r.f | r.ts), r.ts, r.f, 1'b0});
         $display("test %0d done", i);
      end

      // Longest copy, with a second go landing while busy
      wr(`CTPC_OFF_CS, 32'h0000_0023);
      wr(`CTPC_OFF_DESC, d(DT_CALL_GATE, 3, 0));
      wr(`CTPC_OFF_GATE, g(DT_CODE, 0, 5'h1F));
      nf = n_fault;
      go(CT_CALL);
      go(CT_RET);
      wait_idle();
      chk(n_fault - nf, 0);
      chk(cpl_o, 2'h0);
      rd(`CTPC_OFF_STK, q);
      chk(q, 32'h1000_00BE);
      rd(`CTPC_OFF_STATUS, q);
      chk(q[12:8], 5'h1F);
      $display("test copy_busy done");

      // Unmapped and misaligned places read zero, writes vanish
      wr(8'h30, 32'hA5A5_5A5A);
      rd(8'h30, q);
      chk(q, 32'h0000_0000);
      rd(8'h25, q);
      chk(q, 32'h0000_0000);
      $display("test unmapped done");

      // Reset in mid-run returns level and stack to zero
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(cpl_o, 2'h0);
      rd(`CTPC_OFF_STK, q);
      chk(q, `CTPC_RST_STK);
      rd(`CTPC_OFF_STATUS, q);
      chk(q, 32'h0000_0000);
      $display("test reset done");
      summarize();
   end
endmodule
